/* File: rtl/e31_pkg.sv */
// shared constants for the 34 Mbit/s section adaptation block
package e31_pkg;
  // =========================================================
  // framing
  localparam int          FRAME_BITS  = 1536;
  localparam int          FAS_LEN     = 10;
  localparam logic [9:0]  FAS_WORD    = 10'h3D0;
  localparam int          LOSS_MISSES = 4;
  localparam int          REGAIN_HITS = 3;
  // =========================================================
  // all-ones detector: X zeros, Y bit window, Z zeros
  localparam int          AIS_X       = 4;
  localparam int          AIS_Y       = 1536;
  localparam int          AIS_Z       = 5;
  // =========================================================
  // loss of signal and timing
  localparam int          LOS_BITS    = 255;
  localparam int          SYS_CLK_MHZ = 200;
  localparam int          AIS_LIMIT_US = 250;
  localparam int          AIS_LIMIT_CYCLES = AIS_LIMIT_US * SYS_CLK_MHZ;
  // =========================================================
  // types
  typedef enum logic [1:0] {SYM_ZERO, SYM_MARK, SYM_B, SYM_V} sym_e;
  typedef enum logic [1:0] {FA_SEARCH, FA_CONFIRM, FA_INFRAME} frame_e;
endpackage : e31_pkg

/* File: rtl/e31_adaptation.sv */
// HDB3 adaptation source and sinks with framing and defect logic
`timescale 1ns/1ps

// How it works
// - trail signal fail follows the loss-of-signal defect.
// - signal-loss report only in monitored mode while signal is lost.
// - both sources HDB3-encode client data onto the line.
// - line symbols step on client clock edges only, fixed latency.
// - a source drives the line only while active.
// - sinks decode HDB3, restoring substituted zeros.
// - sampling follows each rising line clock edge, so rate offsets of 20 ppm lock.
// - transparent sink outputs data with recovered clock, no frame start.
// - inactive sink outputs all ones; an inactive four-tributary sink reports nothing (signal-loss report is not gated by either sink).
// - transparent sink AIS insert and server fail equal trail fail.
// - all-ones insertion and removal take effect within 250 us.
// - four-tributary sink outputs clock, frame start and data.
// - four consecutive wrong alignment words lose alignment.
// - three consecutive correct words regain alignment.
// - after one found word, a miss in the next two restarts search.
// - frame-loss defect holds from loss until three good words.
// - alarm defect detector uses 4, 1536 and 5.
// - four-tributary insert and server fail are AIS or LOF or TSF.
// - alarm report needs defect, no trail fail, report enable.
// - frame-loss report needs defect, no alarm, no trail fail.
// - either active source drives; both share one encoder, none is denied.
// - port mode input qualifies the signal-loss report.
module e31_adaptation #(
  parameter int FRAME_BITS       = e31_pkg::FRAME_BITS,
  parameter int LOS_BITS         = e31_pkg::LOS_BITS,
  parameter int BUF_DEPTH        = 2,
  parameter int AIS_LIMIT_CYCLES = e31_pkg::AIS_LIMIT_CYCLES
) (
  input  wire logic sys_clk,
  input  wire logic rst_b,
  input  wire logic clientClkIn,
  input  wire logic clientDataIn,
  input  wire logic srcXActive,
  input  wire logic srcEActive,
  output logic      linePosOut,
  output logic      lineNegOut,
  output logic      lineOe,
  input  wire logic lineClk,
  input  wire logic linePosIn,
  input  wire logic lineNegIn,
  input  wire logic portMonitored,
  input  wire logic sinkXActive,
  input  wire logic sinkEActive,
  input  wire logic reportAllOnesEn,
  input  wire logic clientReady,
  output logic      clientValid,
  output logic      clientClkOut,
  output logic      clientDataX,
  output logic      clientDataE,
  output logic      clientFrameStart,
  output logic      bufferOverrun,
  output logic      lossOfSignalDefect,
  output logic      trailSignalFailAction,
  output logic      signalLossReport,
  output logic      frameLossDefect,
  output logic      alarmIndicationDefect,
  output logic      allOnesInsertX,
  output logic      allOnesInsertE,
  output logic      serverFailX,
  output logic      serverFailE,
  output logic      alarmIndicationReport,
  output logic      frameLossReport
);
  // =========================================================
  // input synchronisers
  logic [4:0] syncA_q;
  logic [4:0] syncB_q;
  logic       lineClkPrev_q;
  logic       clientClkPrev_q;
  logic       lineEdge;
  logic       clientEdge;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      syncA_q         <= 5'h00;
      syncB_q         <= 5'h00;
      lineClkPrev_q   <= 1'b0;
      clientClkPrev_q <= 1'b0;
    end else begin
      syncA_q <= {lineClk, linePosIn, lineNegIn, clientClkIn, clientDataIn};
      syncB_q         <= syncA_q;
      lineClkPrev_q   <= syncB_q[4];
      clientClkPrev_q <= syncB_q[1];
    end
  end
  // each rising line clock edge retimes, so a slightly fast or slow line still locks
  assign lineEdge   = syncB_q[4] & ~lineClkPrev_q;
  assign clientEdge = syncB_q[1] & ~clientClkPrev_q;

  // =========================================================
  // source: HDB3 encoder
  e31_pkg::sym_e sym_q [4];
  logic       srcDrive;
  logic       lastPolPos_q;
  logic       oddMarks_q;
  logic       allZero;
  logic       oddNow;

  // either active source drives the line; both share one encoder
  assign srcDrive = srcXActive | srcEActive;
  assign allZero = (sym_q[0] == e31_pkg::SYM_ZERO) &&
                   (sym_q[1] == e31_pkg::SYM_ZERO) &&
                   (sym_q[2] == e31_pkg::SYM_ZERO) && !syncB_q[0];
  // parity must count the symbol leaving on this same client edge
  assign oddNow = (sym_q[3] == e31_pkg::SYM_V) ? 1'b0 :
                  oddMarks_q ^ (sym_q[3] != e31_pkg::SYM_ZERO);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 4; i++) sym_q[i] <= e31_pkg::SYM_ZERO;
    end else if (clientEdge) begin
      sym_q[3] <= sym_q[2];
      sym_q[2] <= sym_q[1];
      sym_q[1] <= sym_q[0];
      sym_q[0] <= syncB_q[0] ? e31_pkg::SYM_MARK : e31_pkg::SYM_ZERO;
      if (allZero) begin
        sym_q[0] <= e31_pkg::SYM_V;
        // even pulse count since last violation needs a balancing B
        sym_q[3] <= oddNow ? e31_pkg::SYM_ZERO : e31_pkg::SYM_B;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      linePosOut   <= 1'b0;
      lineNegOut   <= 1'b0;
      lastPolPos_q <= 1'b0;
      oddMarks_q   <= 1'b0;
    end else if (!srcDrive) begin
      linePosOut <= 1'b0;
      lineNegOut <= 1'b0;
    end else if (clientEdge) begin
      linePosOut <= 1'b0;
      lineNegOut <= 1'b0;
      case (sym_q[3])
        e31_pkg::SYM_MARK, e31_pkg::SYM_B: begin
          linePosOut   <= ~lastPolPos_q;
          lineNegOut   <= lastPolPos_q;
          lastPolPos_q <= ~lastPolPos_q;
          oddMarks_q   <= ~oddMarks_q;
        end
        e31_pkg::SYM_V: begin
          linePosOut <= lastPolPos_q;
          lineNegOut <= ~lastPolPos_q;
          oddMarks_q <= 1'b0;
        end
        default: ;
      endcase
    end
  end
  assign lineOe = srcDrive;

  // =========================================================
  // sink: decoder, loss of signal
  logic [3:0] mark_q;
  logic       rxPolPos_q;
  logic       rxPulse;
  logic       violation;
  logic       rxBit;
  logic [$clog2(LOS_BITS+1)-1:0] losCnt_q;

  assign rxPulse   = syncB_q[3] | syncB_q[2];
  assign violation = rxPulse && (syncB_q[3] == rxPolPos_q);
  assign rxBit     = mark_q[3];

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mark_q     <= 4'h0;
      rxPolPos_q <= 1'b0;
    end else if (lineEdge) begin
      // violation wipes itself and the B three bits earlier
      mark_q <= violation ? 4'h0 : {mark_q[2:0], rxPulse};
      if (rxPulse) rxPolPos_q <= syncB_q[3];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      losCnt_q <= '0;
    end else if (lineEdge) begin
      if (rxPulse) losCnt_q <= '0;
      else if (losCnt_q != LOS_BITS[$bits(losCnt_q)-1:0])
        losCnt_q <= losCnt_q + 1'b1;
    end
  end
  assign lossOfSignalDefect    = losCnt_q == LOS_BITS[$bits(losCnt_q)-1:0];
  assign trailSignalFailAction = lossOfSignalDefect;
  assign signalLossReport = portMonitored & lossOfSignalDefect;

  // =========================================================
  // frame alignment
  e31_pkg::frame_e faState_q;
  logic [e31_pkg::FAS_LEN-1:0] window_q;
  logic [e31_pkg::FAS_LEN-1:0] nextWin;
  logic [$clog2(FRAME_BITS)-1:0] bitCnt_q;
  logic [1:0] count_q;
  logic       checkPos;
  logic       fasHit;

  assign nextWin  = {window_q[e31_pkg::FAS_LEN-2:0], rxBit};
  assign fasHit   = nextWin == e31_pkg::FAS_WORD;
  assign checkPos = bitCnt_q == $bits(bitCnt_q)'(FRAME_BITS - 1);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      faState_q       <= e31_pkg::FA_SEARCH;
      window_q        <= '0;
      bitCnt_q        <= '0;
      count_q         <= 2'h0;
      frameLossDefect <= 1'b1;
    end else if (lineEdge) begin
      window_q <= nextWin;
      bitCnt_q <= checkPos ? '0 : bitCnt_q + 1'b1;
      case (faState_q)
        e31_pkg::FA_SEARCH: if (fasHit) begin
          faState_q <= e31_pkg::FA_CONFIRM;
          bitCnt_q  <= '0;
          count_q   <= 2'h1;
        end
        e31_pkg::FA_CONFIRM: if (checkPos) begin
          if (!fasHit) begin
            faState_q <= e31_pkg::FA_SEARCH;
          end else if (count_q == 2'(e31_pkg::REGAIN_HITS - 1)) begin
            faState_q       <= e31_pkg::FA_INFRAME;
            frameLossDefect <= 1'b0;
            count_q         <= 2'h0;
          end else begin
            count_q <= count_q + 1'b1;
          end
        end
        e31_pkg::FA_INFRAME: if (checkPos) begin
          if (fasHit) begin
            count_q <= 2'h0;
          end else if (count_q == 2'(e31_pkg::LOSS_MISSES - 1)) begin
            faState_q       <= e31_pkg::FA_SEARCH;
            frameLossDefect <= 1'b1;
          end else begin
            count_q <= count_q + 1'b1;
          end
        end
        default: faState_q <= e31_pkg::FA_SEARCH;
      endcase
    end
  end

  // =========================================================
  // all-ones detector
  logic [$clog2(e31_pkg::AIS_Y)-1:0] winCnt_q;
  logic [2:0] zeroCnt_q;
  logic [2:0] zeroNow;
  logic       prevLow_q;
  logic       prevHigh_q;
  logic       winEnd;

  assign zeroNow = zeroCnt_q + 3'(!rxBit && zeroCnt_q != 3'(e31_pkg::AIS_Z));
  assign winEnd  = winCnt_q == $bits(winCnt_q)'(e31_pkg::AIS_Y - 1);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      winCnt_q              <= '0;
      zeroCnt_q             <= 3'h0;
      prevLow_q             <= 1'b0;
      prevHigh_q            <= 1'b0;
      alarmIndicationDefect <= 1'b0;
    end else if (lineEdge) begin
      winCnt_q  <= winEnd ? '0 : winCnt_q + 1'b1;
      zeroCnt_q <= winEnd ? 3'h0 : zeroNow;
      if (winEnd) begin
        prevLow_q  <= zeroNow < 3'(e31_pkg::AIS_X);
        prevHigh_q <= zeroNow >= 3'(e31_pkg::AIS_Z);
        if (prevLow_q && zeroNow < 3'(e31_pkg::AIS_X))
          alarmIndicationDefect <= 1'b1;
        else if (prevHigh_q && zeroNow >= 3'(e31_pkg::AIS_Z))
          alarmIndicationDefect <= 1'b0;
      end
    end
  end

  // =========================================================
  // consequent actions and correlations
  assign allOnesInsertX = trailSignalFailAction;
  assign serverFailX    = trailSignalFailAction;
  assign allOnesInsertE = alarmIndicationDefect | frameLossDefect |
                          trailSignalFailAction;
  assign serverFailE    = allOnesInsertE;
  assign alarmIndicationReport = sinkEActive & alarmIndicationDefect &
    ~trailSignalFailAction & reportAllOnesEn;
  assign frameLossReport = sinkEActive & frameLossDefect &
    ~alarmIndicationDefect & ~trailSignalFailAction;

  // =========================================================
  // two-entry output buffer: {frame start, four-trib, transparent}
  logic [2:0] bufMem_q [BUF_DEPTH];
  logic [$clog2(BUF_DEPTH)-1:0] wrPtr_q;
  logic [$clog2(BUF_DEPTH)-1:0] rdPtr_q;
  logic [$clog2(BUF_DEPTH):0]   fill_q;
  logic       push;
  logic       pop;
  logic       bufReady;
  logic [2:0] bufIn;

  assign bufReady = fill_q != ($bits(fill_q))'(BUF_DEPTH);
  assign push     = lineEdge & bufReady;
  assign pop      = clientValid & clientReady;
  assign clientValid = fill_q != '0;
  // inactive sinks force ones; frame start only with alignment
  assign bufIn = {checkPos & fasHit & (faState_q == e31_pkg::FA_INFRAME),
                  rxBit | allOnesInsertE | ~sinkEActive,
                  rxBit | allOnesInsertX | ~sinkXActive};

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < BUF_DEPTH; i++) bufMem_q[i] <= 3'h0;
      wrPtr_q       <= '0;
      rdPtr_q       <= '0;
      fill_q        <= '0;
      bufferOverrun <= 1'b0;
    end else begin
      bufferOverrun <= lineEdge & ~bufReady;
      if (push) begin
        bufMem_q[wrPtr_q] <= bufIn;
        wrPtr_q <= wrPtr_q + 1'b1;
      end
      if (pop) rdPtr_q <= rdPtr_q + 1'b1;
      fill_q <= fill_q + ($bits(fill_q))'(push) - ($bits(fill_q))'(pop);
    end
  end
  assign clientDataX      = bufMem_q[rdPtr_q][0];
  assign clientDataE      = bufMem_q[rdPtr_q][1];
  assign clientFrameStart = bufMem_q[rdPtr_q][2];
  assign clientClkOut     = lineClkPrev_q;

  // =========================================================
  // checks
  logic [31:0] aisWait_q;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) aisWait_q <= '0;
    else if (allOnesInsertE && clientValid && !clientDataE)
      aisWait_q <= aisWait_q + 1'b1;
    else if (!allOnesInsertE) aisWait_q <= '0;
  end

  sequence s_miss;
    lineEdge && checkPos && !fasHit;
  endsequence
  sequence s_inframe_miss;
    (faState_q == e31_pkg::FA_INFRAME) and s_miss;
  endsequence

  a_tsf_follows_los: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $rose(lossOfSignalDefect) |-> trailSignalFailAction)
    else $error("trail fail not raised with loss of signal");
  a_loss_report: assert property (@(posedge sys_clk) disable iff (!rst_b)
    signalLossReport |-> portMonitored && lossOfSignalDefect)
    else $error("signal loss report without cause");
  a_src_undriven: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !srcDrive |-> !lineOe ##1 (!linePosOut && !lineNegOut))
    else $error("inactive source drives line");
  a_line_timing: assert property (@(posedge sys_clk) disable iff (!rst_b)
    srcDrive && $past(srcDrive) && $changed(linePosOut) |-> $past(clientEdge))
    else $error("line symbol moved without client edge");
  a_los_count: assert property (@(posedge sys_clk) disable iff (!rst_b)
    lineEdge && rxPulse |=> !lossOfSignalDefect)
    else $error("loss of signal held after a pulse");
  a_lof_set: assert property (@(posedge sys_clk) disable iff (!rst_b)
    s_inframe_miss and (count_q == 2'h3) |=> frameLossDefect)
    else $error("alignment not lost after four misses");
  a_confirm_miss: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (faState_q == e31_pkg::FA_CONFIRM) and s_miss |=>
      faState_q == e31_pkg::FA_SEARCH && frameLossDefect)
    else $error("search not restarted after confirm miss");
  a_x_follow: assert property (@(posedge sys_clk) disable iff (!rst_b)
    serverFailX == trailSignalFailAction && allOnesInsertX == serverFailX)
    else $error("transparent actions differ from trail fail");
  a_frame_loss_report_gate: assert property (@(posedge sys_clk) disable iff (!rst_b)
    frameLossReport |-> !alarmIndicationDefect && !trailSignalFailAction)
    else $error("frame loss report while masked");
  a_alarm_indication_report_gate: assert property (@(posedge sys_clk) disable iff (!rst_b)
    alarmIndicationReport |-> reportAllOnesEn && !trailSignalFailAction)
    else $error("alarm report while masked");
  a_ais_limit: assert property (@(posedge sys_clk) disable iff (!rst_b)
    aisWait_q < 32'(AIS_LIMIT_CYCLES))
    else $error("all ones not inserted in time");
endmodule : e31_adaptation

/* File: tb/e31_line_partner.sv */
// far-end line equipment model: HDB3 sender with co-directional clock
`timescale 1ns/1ps
module e31_line_partner (
  output logic lineClk,
  output logic linePos,
  output logic lineNeg
);
  // ==========
  // encoder state
  logic q[$];
  logic lastPos = 1'b0;
  int   sinceV  = 0;
  initial begin
    lineClk = 1'b0;
    linePos = 1'b0;
    lineNeg = 1'b0;
  end

  // ==========
  // symbols
  // clock runs only while a symbol goes out; rails move while it is low
  task automatic emit(input logic p, input logic n);
    linePos = p;
    lineNeg = n;
    #32 lineClk = 1'b1;
    #32 lineClk = 1'b0;
  endtask : emit

  // a violation repeats the last polarity, any other mark alternates
  task automatic pulse(input logic viol);
    lastPos = viol ? lastPos : ~lastPos;
    sinceV  = viol ? 0 : sinceV + 1;
    emit(lastPos, ~lastPos);
  endtask : pulse

  // four bits of lookahead so a zero run can be substituted whole
  task automatic sendBit(input logic b);
    q.push_back(b);
    if (q.size() == 4) begin
      if (!(q[0] | q[1] | q[2] | q[3])) begin
        if (sinceV % 2 == 0) pulse(1'b0);
        else emit(1'b0, 1'b0);
        emit(1'b0, 1'b0);
        emit(1'b0, 1'b0);
        pulse(1'b1);
        q.delete();
      end else begin
        if (q[0]) pulse(1'b0);
        else emit(1'b0, 1'b0);
        void'(q.pop_front());
      end
    end
  endtask : sendBit

  // clocked spaces with no substitution: a dead line
  task automatic sendRaw(input int n);
    repeat (n) emit(1'b0, 1'b0);
  endtask : sendRaw

  // clock stopped: rails no longer carry the last symbol
  task automatic idle();
    linePos = ~linePos;
    lineNeg = ~lineNeg;
  endtask : idle
endmodule : e31_line_partner

/* File: tb/e31_adaptation_tb.sv */
// self-checking bench for the 34 Mbit/s section adaptation block
`timescale 1ns/1ps
module e31_adaptation_tb;
  // ==========
  // signals
  localparam int          FB  = 64;
  localparam logic [23:0] PAT = 24'h08700F;
  logic sys_clk = 1'b0;
  logic rst_b;
  logic clientClkIn, clientDataIn, srcXActive, srcEActive;
  logic linePosOut, lineNegOut, lineOe, lineClk, linePosIn, lineNegIn;
  logic portMonitored, sinkXActive, sinkEActive, reportAllOnesEn;
  logic clientReady, clientValid, clientClkOut, clientDataX, clientDataE;
  logic clientFrameStart, bufferOverrun, lossOfSignalDefect;
  logic trailSignalFailAction, signalLossReport, frameLossDefect;
  logic alarmIndicationDefect, allOnesInsertX, allOnesInsertE;
  logic serverFailX, serverFailE, alarmIndicationReport, frameLossReport;
  logic rxQ[$];
  logic lastP;
  int   badCount = 0;
  int   cmpCount = 0;
  int   fsCount  = 0;
  int   ovrCount = 0;
  int   cyc      = 0;
  int   pulses;
  int   ckCount  = 0;
  int   n0;
  logic ckPrev;
  logic lastE;

  e31_adaptation #(.FRAME_BITS(FB), .LOS_BITS(16)) i_dut (
    .sys_clk, .rst_b, .clientClkIn, .clientDataIn, .srcXActive,
    .srcEActive, .linePosOut, .lineNegOut, .lineOe, .lineClk, .linePosIn,
    .lineNegIn, .portMonitored, .sinkXActive, .sinkEActive,
    .reportAllOnesEn, .clientReady, .clientValid, .clientClkOut,
    .clientDataX, .clientDataE, .clientFrameStart, .bufferOverrun,
    .lossOfSignalDefect, .trailSignalFailAction, .signalLossReport,
    .frameLossDefect, .alarmIndicationDefect, .allOnesInsertX,
    .allOnesInsertE, .serverFailX, .serverFailE, .alarmIndicationReport,
    .frameLossReport
  );
  e31_line_partner i_far (.lineClk, .linePos(linePosIn), .lineNeg(lineNegIn));

  always #2.5 sys_clk = ~sys_clk;

  // ==========
  // monitor and timeout
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (clientValid === 1'b1 && clientReady === 1'b1) begin
      rxQ.push_back(clientDataX);
      lastE = clientDataE;
      if (clientFrameStart === 1'b1) fsCount++;
    end
    if (bufferOverrun === 1'b1) ovrCount++;
    ckPrev <= clientClkOut;
    if (clientClkOut === 1'b1 && ckPrev === 1'b0) ckCount++;
    if (cyc == 90000) begin
      badCount++;
      testDone();
    end
  end

  // ==========
  // tasks
  task automatic testDone();
    $display("comparisons %0d mismatches %0d", cmpCount, badCount);
    if (badCount == 0 && cmpCount > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : testDone

  task automatic chk1(input string n, input logic e, input logic g);
    cmpCount++;
    if (g !== e) begin
      badCount++;
      $display("mismatch %s expected %b seen %b", n, e, g);
    end
  endtask : chk1

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick

  task automatic setSrc(input logic x, input logic e);
    srcXActive <= x;
    srcEActive <= e;
  endtask : setSrc

  // sinks move on a clock edge even when called after a line transfer
  task automatic setSink(input logic a);
    tick(1);
    sinkXActive <= a;
    sinkEActive <= a;
  endtask : setSink

  // client clock period of 16 cycles leaves the sync pipe time to settle
  task automatic srcBit(input logic b);
    clientDataIn <= b;
    tick(4);
    clientClkIn <= 1'b1;
    tick(8);
    clientClkIn <= 1'b0;
    tick(4);
  endtask : srcBit

  task automatic sendFrame(input logic good);
    logic [9:0] w;
    w = e31_pkg::FAS_WORD ^ {9'h000, ~good};
    for (int i = 9; i >= 0; i--) i_far.sendBit(w[i]);
    for (int i = 0; i < FB - 10; i++) i_far.sendBit(logic'(i % 2 == 0));
  endtask : sendFrame

  // ==========
  // sequence
  initial begin
    rst_b = 1'b0;
    clientClkIn = 1'b0;
    clientDataIn = 1'b0;
    srcXActive = 1'b0;
    srcEActive = 1'b0;
    portMonitored = 1'b0;
    sinkXActive = 1'b1;
    sinkEActive = 1'b1;
    reportAllOnesEn = 1'b1;
    clientReady = 1'b1;
    tick(16);
    rst_b <= 1'b1;
    tick(4);
    chk1("lof at reset", 1'b1, frameLossDefect);
    chk1("valid at reset", 1'b0, clientValid);
    setSrc(1'b1, 1'b0);
    tick(2);
    chk1("oe x", 1'b1, lineOe);
    repeat (8) srcBit(1'b1);
    lastP = linePosOut;
    for (int i = 0; i < 12; i++) begin
      srcBit(1'b1);
      chk1("mark", 1'b1, linePosOut ^ lineNegOut);
      chk1("alternation", ~lastP, linePosOut);
      lastP = linePosOut;
    end
    repeat (8) srcBit(1'b0);
    pulses = 0;
    for (int i = 0; i < 12; i++) begin
      srcBit(1'b0);
      pulses += int'(linePosOut | lineNegOut);
    end
    // twenty marks, then every group after a violation: B00V, 2 pulses
    chk1("zero run pulses", 1'b1, logic'(pulses == 6));
    setSrc(1'b0, 1'b1);
    srcBit(1'b1);
    chk1("oe e", 1'b1, lineOe);
    setSrc(1'b0, 1'b0);
    tick(2);
    chk1("oe off", 1'b0, lineOe);
    chk1("rails off", 1'b0, linePosOut | lineNegOut);
    repeat (8) i_far.sendBit(1'b1);
    tick(60);
    rxQ.delete();
    for (int i = 23; i >= 0; i--) i_far.sendBit(PAT[i]);
    repeat (8) i_far.sendBit(1'b1);
    i_far.idle();
    tick(60);
    while (rxQ.size() > 0 && rxQ[0] === 1'b1) void'(rxQ.pop_front());
    for (int i = 0; i < 24; i++) chk1("decoded", PAT[23 - i], rxQ[i]);
    // receiver stalls: two entries fill, further line bits are refused
    clientReady <= 1'b0;
    n0 = ckCount;
    repeat (8) i_far.sendBit(1'b1);
    tick(4);
    chk1("valid stalled", 1'b1, clientValid);
    chk1("recovered clock", 1'b1, logic'(ckCount - n0 == 8));
    chk1("overrun", 1'b1, logic'(ovrCount > 0));
    clientReady <= 1'b1;
    tick(4);
    chk1("drained", 1'b0, clientValid);
    setSink(1'b0);
    tick(2);
    rxQ.delete();
    repeat (12) i_far.sendBit(1'b0);
    chk1("lof hidden", 1'b0, frameLossReport);
    chk1("pops while off", 1'b1, logic'(rxQ.size() > 0));
    foreach (rxQ[i]) chk1("ones while off", 1'b1, rxQ[i]);
    setSink(1'b1);
    tick(2);
    chk1("lof report", 1'b1, frameLossReport);
    for (int f = 0; f < 4; f++) begin
      sendFrame(1'b1);
      chk1("lof regain", logic'(f < 2), frameLossDefect);
    end
    chk1("frame start", 1'b1, logic'(fsCount > 0));
    chk1("insert e clear", 1'b0, allOnesInsertE);
    for (int f = 0; f < 4; f++) begin
      sendFrame(1'b0);
      chk1("lof loss", logic'(f == 3), frameLossDefect);
    end
    chk1("insert e", 1'b1, allOnesInsertE);
    chk1("fail e", 1'b1, serverFailE);
    chk1("fail x", 1'b0, serverFailX);
    sendFrame(1'b1);
    sendFrame(1'b0);
    sendFrame(1'b1);
    sendFrame(1'b1);
    chk1("restart", 1'b1, frameLossDefect);
    sendFrame(1'b1);
    chk1("regained", 1'b0, frameLossDefect);
    tick(1);
    portMonitored <= 1'b1;
    i_far.sendRaw(24);
    tick(4);
    chk1("los", 1'b1, lossOfSignalDefect);
    chk1("tsf", 1'b1, trailSignalFailAction);
    chk1("los report", 1'b1, signalLossReport);
    chk1("insert x", 1'b1, allOnesInsertX);
    chk1("fail x los", 1'b1, serverFailX);
    chk1("fail e los", 1'b1, serverFailE);
    chk1("lof report tsf", 1'b0, frameLossReport);
    chk1("ones on loss", 1'b1, rxQ[$]);
    chk1("e ones on loss", 1'b1, lastE);
    portMonitored <= 1'b0;
    tick(2);
    chk1("los report off", 1'b0, signalLossReport);
    repeat (8) i_far.sendBit(1'b1);
    tick(4);
    chk1("tsf clear", 1'b0, trailSignalFailAction);
    chk1("insert x clear", 1'b0, allOnesInsertX);
    // no full window of ones can have passed yet
    repeat (1500) i_far.sendBit(1'b1);
    chk1("ais early", 1'b0, alarmIndicationDefect);
    repeat (3172) i_far.sendBit(1'b1);
    chk1("ais", 1'b1, alarmIndicationDefect);
    chk1("insert e ais", 1'b1, allOnesInsertE);
    chk1("ais report", 1'b1, alarmIndicationReport);
    chk1("lof report ais", 1'b0, frameLossReport);
    tick(1);
    reportAllOnesEn <= ~reportAllOnesEn;
    tick(2);
    chk1("ais report off", 1'b0, alarmIndicationReport);
    testDone();
  end
endmodule : e31_adaptation_tb
